/* pm_pkg.sv */
/*
 * constants, field layout, reset values, timing counts and state codes of the
 * power-management block. assumes a 200 MHz system clock.
 */
// Operation
// - capability structure of two dwords at 0x40, id 0x01, next pointer 0x00.
// - capability pointer byte of the header reads 0x40.
// - wake-support bits 31:27 read 01000b, bits 26:20 read zero.
// - capability bit 19 reads 1, version bits 18:16 read 010b.
// - data byte and bridge-support byte of second dword read zero.
// - wake-event status at bit 15, resets 0, write 1 clears, 0 keeps.
// - wake-enable at bit 8, resets 0, gates the wake request in D3hot.
// - two-bit power state at bits 1:0, resets 00b, other bits zero.
// - power-up or leaving D3hot gives D0-uninitialized; init gives D0-active.
// - D0-active answers all transactions and may raise its interrupt.
// - D3hot answers config only, ignores memory, holds interrupt off.
// - D3hot keeps serial receive and flow control running.
// - in D3hot a low receive input on any channel is a wake event.
// - in D3hot any set modem-delta flag of eight channels is a wake event.
// - wake-event status sets on every wake event, regardless of enable.
// - leaving D3hot for D0 keeps all internal register values.
// - bus output drivers stay disabled during the D3hot to D0 transition.
// - wake context kept unchanged throughout D3hot.
// - bus reset brings every register and output to defaults, D0-uninit.
package pm_pkg;
	localparam int         NUM_CH        = 8;
	localparam int         DELTA_W       = 4;
	// configuration offsets
	localparam logic [7:0] CAP_PTR_OFS   = 8'h34;
	localparam logic [7:0] CAPW_OFS      = 8'h40;
	localparam logic [7:0] CSW_OFS       = 8'h44;
	// capability dword contents
	localparam logic [7:0] CAP_ID        = 8'h01;
	localparam logic [7:0] NEXT_PTR      = 8'h00;
	localparam logic [4:0] WAKE_SUPPORT  = 5'h08;
	localparam logic [6:0] CAP_RSVD      = 7'h00;
	localparam logic [0:0] WAKE_CLK_REQ  = 1'h1;
	localparam logic [2:0] PM_VERSION    = 3'h2;
	localparam logic [7:0] DATA_BYTE     = 8'h00;
	localparam logic [7:0] BRIDGE_BYTE   = 8'h00;
	// control/status field positions
	localparam int         WAKE_STS_BIT  = 15;
	localparam int         WAKE_EN_BIT   = 8;
	localparam int         PSTATE_LSB    = 0;
	// encodings and reset values
	localparam logic [1:0] PSTATE_D0     = 2'h0;
	localparam logic [1:0] PSTATE_D3HOT  = 2'h3;
	localparam logic [1:0] PSTATE_RST    = 2'h0;
	localparam logic       WAKE_STS_RST  = 1'h0;
	localparam logic       WAKE_EN_RST   = 1'h0;
	// driver-off recovery window on leaving D3hot
	localparam int         CLK_PERIOD_NS = 5;
	localparam int         RECOVER_NS    = 100;
	localparam int         RECOVER_CYC   = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         RCNT_W        = 5;

	typedef enum logic [3:0] {
		ST_D0_UNINIT = 4'h1,
		ST_D0_ACTIVE = 4'h2,
		ST_D3HOT     = 4'h4,
		ST_RECOVER   = 4'h8
	} pm_state_t;
endpackage : pm_pkg

/* wake_if.sv */
/*
 * carrier between the receive-pin synchroniser, the wake detector and the core.
 * assumes all three share the system clock.
 */
`timescale 1ns/1ps
interface wake_if;
	logic [pm_pkg::NUM_CH-1:0] rx_low;   // synchronised, high while a pin is low
	logic                      wake_hit; // wake condition seen this cycle

	modport sync (output rx_low);
	modport det  (input rx_low, output wake_hit);
	modport core (input wake_hit);
endinterface : wake_if

/* rx_pin_sync.sv */
/*
 * two-stage synchroniser for the serial receive pins of all channels.
 * assumes the pins are asynchronous to the system clock.
 */
`timescale 1ns/1ps
module rx_pin_sync (
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_srst,
	input  wire logic                      i_clk_en,
	input  wire logic [pm_pkg::NUM_CH-1:0] i_rx_pin,
	wake_if.sync                           wif
);
	import pm_pkg::*;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			logic meta_q;
			logic sync_q;
			// idle line is high, so reset to high to avoid a false start
			always_ff @(posedge i_sys_clk) begin
				if (i_srst) begin
					meta_q <= 1'b1;
					sync_q <= 1'b1;
				end else if (i_clk_en) begin
					meta_q <= i_rx_pin[ch];
					sync_q <= meta_q;
				end
			end
			assign wif.rx_low[ch] = ~sync_q;
		end
	endgenerate
endmodule : rx_pin_sync

/* wake_detect.sv */
/*
 * combines start-bit levels and modem-delta flags into one wake condition.
 * assumes delta flags come from the channel logic on the system clock.
 */
`timescale 1ns/1ps
module wake_detect (
	input  wire logic                                     i_in_d3hot,
	input  wire logic [pm_pkg::NUM_CH*pm_pkg::DELTA_W-1:0] i_msr_delta,
	wake_if.det                                           wif
);
	import pm_pkg::*;

	logic [NUM_CH-1:0] ch_delta;

	// per channel: any of the four modem-input change flags
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			assign ch_delta[ch] = |i_msr_delta[ch*DELTA_W +: DELTA_W];
		end
	endgenerate

	// only counts while in D3hot; a level, so a held start bit keeps re-setting
	assign wif.wake_hit = i_in_d3hot & ((|wif.rx_low) | (|ch_delta));
endmodule : wake_detect

/* pci_power_mgmt_states.sv */
/*
 * power-management capability of the serial controller: capability dwords,
 * control/status field, D0/D3hot state machine, wake request and gating of
 * memory claims, interrupt and bus drivers.
 * assumes a configuration decoder on the same clock presents dword accesses
 * with byte enables, and channel logic supplies modem-delta flags and interrupt.
 * limitations: the end of software set-up is read from the memory-space enable
 * level, and recovery always passes through D0-uninitialized before D0-active.
 * the wake request is open-drain: its level is always low, only the enable moves.
 */
`timescale 1ns/1ps
module pci_power_mgmt_states (
	input  wire logic                                      i_sys_clk,
	input  wire logic                                      i_srst,
	input  wire logic                                      i_clk_en,
	// configuration access
	input  wire logic                                      i_cfg_req,
	input  wire logic                                      i_cfg_we,
	input  wire logic [7:0]                                i_cfg_addr,
	input  wire logic [3:0]                                i_cfg_be,
	input  wire logic [31:0]                               i_cfg_wdata,
	output logic                                           o_cfg_ack,
	output logic [31:0]                                    o_cfg_rdata,
	// memory space claim
	input  wire logic                                      i_mem_req,
	input  wire logic                                      i_mem_space_en,
	output logic                                           o_mem_ack,
	// channel side
	input  wire logic                                      i_uart_irq,
	input  wire logic [pm_pkg::NUM_CH-1:0]                 i_rx_pin,
	input  wire logic [pm_pkg::NUM_CH*pm_pkg::DELTA_W-1:0] i_msr_delta,
	output logic                                           o_inta_n,
	output logic                                           o_rx_run,
	output logic                                           o_in_d3hot,
	output logic                                           o_pci_drv_en,
	// open-drain wake request
	output logic                                           o_pme_out,
	output logic                                           o_pme_oe
);
	import pm_pkg::*;

	localparam logic [RCNT_W-1:0] RECOVER_LAST = RCNT_W'(RECOVER_CYC - 1);

	pm_state_t         state_q;
	pm_state_t         state_d;
	logic [1:0]        pstate_q;
	logic              wake_sts_q;
	logic              wake_en_q;
	logic [RCNT_W-1:0] rcnt_q;
	logic              in_d3;
	logic              cfg_live;
	logic              csw_wr;
	logic              cap_hit;
	logic              capw_hit;
	logic              csw_hit;
	logic              wr_to_d0;
	logic              wr_to_d3;
	logic [31:0]       capw_word;
	logic [31:0]       csw_word;
	logic [31:0]       rd_mux;
	logic              irq_ok;
	logic              cfg_rd;
	logic              owned_hit;
	logic              en_wr;
	logic              sts_clr;
	logic              func_live;

	wake_if wif ();

	// receive pins are asynchronous and need two stages before use
	rx_pin_sync u_rx_sync (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_clk_en  (i_clk_en),
		.i_rx_pin  (i_rx_pin),
		.wif       (wif)
	);

	// wake condition from start bits and modem changes
	wake_detect u_wake_det (
		.i_in_d3hot  (in_d3),
		.i_msr_delta (i_msr_delta),
		.wif         (wif)
	);

	// the wake detector listens only while the machine sits in D3hot
	assign in_d3 = (state_q == ST_D3HOT);

	// full function only in D0-active; one signal so memory and interrupt agree
	assign func_live = (state_q == ST_D0_ACTIVE);

	// config space is dead only while drivers are off in recovery
	// D3hot keeps answering it, so software can always bring the part back
	assign cfg_live = (state_q != ST_RECOVER);

	// address decode of the three dwords this block owns
	// whole byte address compared; dword accesses keep the low two bits zero
	always_comb begin
		cap_hit  = (i_cfg_addr == CAP_PTR_OFS);
		capw_hit = (i_cfg_addr == CAPW_OFS);
		csw_hit  = (i_cfg_addr == CSW_OFS);
	end

	// any owned dword; other offsets belong to the rest of the header
	assign owned_hit = cap_hit | capw_hit | csw_hit;

	// a read request of any offset refreshes the read register
	assign cfg_rd = i_cfg_req & ~i_cfg_we;

	// a write strobe into the control/status dword
	assign csw_wr = i_cfg_req & i_cfg_we & csw_hit & cfg_live;

	// byte 1 carries both the enable and the write-one clear of the status
	assign en_wr   = csw_wr & i_cfg_be[1];
	assign sts_clr = en_wr & i_cfg_wdata[WAKE_STS_BIT];

	// power-state writes; the two reserved codes decode to neither request
	// so a reserved code leaves both the field and the machine untouched
	always_comb begin
		wr_to_d0 = 1'b0;
		wr_to_d3 = 1'b0;
		if (csw_wr && i_cfg_be[0]) begin
			case (i_cfg_wdata[PSTATE_LSB +: 2])
				PSTATE_D0:    wr_to_d0 = 1'b1;
				PSTATE_D3HOT: wr_to_d3 = 1'b1;
				default: begin
					wr_to_d0 = 1'b0;
					wr_to_d3 = 1'b0;
				end
			endcase
		end
	end

	// power state machine
	// an illegal one-hot code falls back to the power-on state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_D0_UNINIT: begin
				if (wr_to_d3) begin
					state_d = ST_D3HOT;
				end else if (i_mem_space_en) begin
					state_d = ST_D0_ACTIVE;
				end
			end
			ST_D0_ACTIVE: begin
				if (wr_to_d3) begin
					state_d = ST_D3HOT;
				end
			end
			ST_D3HOT: begin
				if (wr_to_d0) begin
					state_d = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (rcnt_q == RECOVER_LAST) begin
					state_d = ST_D0_UNINIT;
				end
			end
			default: begin
				state_d = ST_D0_UNINIT;
			end
		endcase
	end

	// state register; bus reset or the end of recovery returns it to the power-on state
	// a low clock enable freezes it together with every other flop
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_q <= ST_D0_UNINIT;
		end else if (i_clk_en) begin
			state_q <= state_d;
		end
	end

	// counts the driver-off window after leaving D3hot
	// cleared outside recovery so each exit from D3hot gets the full window
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			rcnt_q <= '0;
		end else if (i_clk_en) begin
			if (state_q == ST_RECOVER) begin
				rcnt_q <= rcnt_q + RCNT_W'(1);
			end else begin
				rcnt_q <= '0;
			end
		end
	end

	// power-state field follows accepted writes only
	// writes during recovery are not accepted, so the field cannot race the counter
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			pstate_q <= PSTATE_RST;
		end else if (i_clk_en) begin
			if (wr_to_d3) begin
				pstate_q <= PSTATE_D3HOT;
			end else if (wr_to_d0) begin
				pstate_q <= PSTATE_D0;
			end
		end
	end

	// wake enable; untouched by state changes so context survives D3hot
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			wake_en_q <= WAKE_EN_RST;
		end else if (i_clk_en) begin
			if (en_wr) begin
				wake_en_q <= i_cfg_wdata[WAKE_EN_BIT];
			end
		end
	end

	// wake status: set wins over a same-cycle write-one clear
	// so an event arriving while software clears is never lost
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			wake_sts_q <= WAKE_STS_RST;
		end else if (i_clk_en) begin
			if (wif.wake_hit) begin
				wake_sts_q <= 1'b1;
			end else if (sts_clr) begin
				wake_sts_q <= 1'b0;
			end
		end
	end

	// capability dword is constant
	// fields packed from the top bit down to the id byte
	assign capw_word = {WAKE_SUPPORT, CAP_RSVD, WAKE_CLK_REQ, PM_VERSION,
	                    NEXT_PTR, CAP_ID};

	// control/status dword; reserved bits read zero
	// the live fields are laid over the zero pattern by position
	always_comb begin
		csw_word                       = {DATA_BYTE, BRIDGE_BYTE, 16'h0000};
		csw_word[WAKE_STS_BIT]         = wake_sts_q;
		csw_word[WAKE_EN_BIT]          = wake_en_q;
		csw_word[PSTATE_LSB +: 2]      = pstate_q;
	end

	// read data select
	// unowned offsets read zero here but are never acknowledged
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (cap_hit) begin
			rd_mux = {24'h00_0000, CAPW_OFS};
		end else if (capw_hit) begin
			rd_mux = capw_word;
		end else if (csw_hit) begin
			rd_mux = csw_word;
		end
	end

	// config answer one cycle after the request, in every state but recovery
	// drivers are off in recovery, so an answer then would reach a dead bus
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_cfg_ack <= 1'b0;
		end else if (i_clk_en) begin
			o_cfg_ack <= i_cfg_req & cfg_live & owned_hit;
		end
	end

	// read data register; holds between reads
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_cfg_rdata <= 32'h0000_0000;
		end else if (i_clk_en && cfg_rd) begin
			o_cfg_rdata <= rd_mux;
		end
	end

	// memory claims only when fully active; ignored in D3hot
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_mem_ack <= 1'b0;
		end else if (i_clk_en) begin
			o_mem_ack <= i_mem_req & func_live;
		end
	end

	// interrupt allowed in D0-active, suppressed in D3hot
	assign irq_ok = func_live & i_uart_irq;

	// active-low interrupt output, registered
	// a pending channel interrupt is held back, not lost, while in D3hot
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_inta_n <= 1'b1;
		end else if (i_clk_en) begin
			o_inta_n <= ~irq_ok;
		end
	end

	// wake request level; the pin is open-drain, so only its enable ever moves
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_pme_out <= 1'b0;
		end else if (i_clk_en) begin
			o_pme_out <= 1'b0;
		end
	end

	// wake request pulls low only while status and enable are both set
	// not gated by state: status sets only in D3hot, and a pending request
	// has to outlive the move back to D0 until software clears it
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_pme_oe <= 1'b0;
		end else if (i_clk_en) begin
			o_pme_oe <= wake_sts_q & wake_en_q;
		end
	end

	// bus drivers off through the whole D3hot to D0 recovery
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_pci_drv_en <= 1'b1;
		end else if (i_clk_en) begin
			o_pci_drv_en <= (state_d != ST_RECOVER);
		end
	end

	// receive path and flow control never stop for power state
	// a trade-off: receive power is spent in D3hot so start bits can wake us
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rx_run <= 1'b1;
		end else if (i_clk_en) begin
			o_rx_run <= 1'b1;
		end
	end

	// D3hot flag, from the next state so it turns with the machine
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_in_d3hot <= 1'b0;
		end else if (i_clk_en) begin
			o_in_d3hot <= (state_d == ST_D3HOT);
		end
	end
endmodule : pci_power_mgmt_states

/* pm_monitor.sv */
/*
 * concurrent checks on the ports of the power-management block.
 * assumes the clock enable is high whenever a request is checked.
 */
`timescale 1ns/1ps
module pm_monitor (
	input wire logic        i_sys_clk,
	input wire logic        i_srst,
	input wire logic        i_clk_en,
	input wire logic        i_cfg_req,
	input wire logic        i_cfg_we,
	input wire logic [7:0]  i_cfg_addr,
	input wire logic [3:0]  i_cfg_be,
	input wire logic [31:0] i_cfg_wdata,
	input wire logic        o_cfg_ack,
	input wire logic [31:0] o_cfg_rdata,
	input wire logic        i_mem_req,
	input wire logic        o_mem_ack,
	input wire logic        o_inta_n,
	input wire logic        o_rx_run,
	input wire logic        o_in_d3hot,
	input wire logic        o_pci_drv_en,
	input wire logic        o_pme_oe
);
	import pm_pkg::*;
	logic take;
	logic wr_cs;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);

	// requests are only answered with drivers on, so recovery is excluded
	assign take  = i_cfg_req && i_clk_en && o_pci_drv_en;
	assign wr_cs = take && i_cfg_we && i_cfg_addr == CSW_OFS;

	a_cap_read: assert property (take && !i_cfg_we && i_cfg_addr == CAPW_OFS |=>
		o_cfg_ack && o_cfg_rdata == 32'h400a_0001) else $error("capability dword wrong");
	a_ptr_read: assert property (take && !i_cfg_we && i_cfg_addr == CAP_PTR_OFS |=>
		o_cfg_ack && o_cfg_rdata == 32'h0000_0040) else $error("capability pointer wrong");
	a_mem_ignored: assert property (o_in_d3hot && i_mem_req |=> !o_mem_ack)
		else $error("memory claimed in D3hot");
	a_irq_held_off: assert property (o_in_d3hot && $past(o_in_d3hot) |-> o_inta_n)
		else $error("interrupt in D3hot");
	a_rx_kept: assert property (o_rx_run) else $error("receive stopped");
	a_d3_enter: assert property (wr_cs && i_cfg_be[0] && i_cfg_wdata[1:0] == 2'b11
		|=> o_in_d3hot) else $error("D3hot not entered");
	a_code_kept: assert property (wr_cs && i_cfg_be[0] && ^i_cfg_wdata[1:0]
		&& !o_in_d3hot |=> !o_in_d3hot) else $error("reserved code changed state");
	a_drv_off: assert property (wr_cs && i_cfg_be[0] && i_cfg_wdata[1:0] == 2'b00
		&& o_in_d3hot |=> (!o_pci_drv_en && !o_in_d3hot) [*8]) else $error("drivers on early");
	a_pme_drop: assert property (wr_cs && i_cfg_be[1] && !i_cfg_wdata[8] |-> ##2 !o_pme_oe)
		else $error("wake request kept without enable");
endmodule : pm_monitor

bind pci_power_mgmt_states pm_monitor pm_monitor_i (.i_sys_clk, .i_srst, .i_clk_en, .i_cfg_req,
	.i_cfg_we, .i_cfg_addr, .i_cfg_be, .i_cfg_wdata, .o_cfg_ack, .o_cfg_rdata, .i_mem_req,
	.o_mem_ack, .o_inta_n, .o_rx_run, .o_in_d3hot, .o_pci_drv_en, .o_pme_oe);

/* pm_host_model.sv */
/*
 * host bridge model: issues configuration dword accesses.
 * assumes the block answers one cycle after the request edge.
 */
`timescale 1ns/1ps
module pm_host_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_cfg_ack,
	input  wire logic [31:0] i_cfg_rdata,
	output logic             o_cfg_req,
	output logic             o_cfg_we,
	output logic [7:0]       o_cfg_addr,
	output logic [3:0]       o_cfg_be,
	output logic [31:0]      o_cfg_wdata
);
	// idle bus; request and write enable low, address, byte enables and write data zero
	initial begin
		o_cfg_req   = 1'b0;
		o_cfg_we    = 1'b0;
		o_cfg_addr  = 8'h00;
		o_cfg_be    = 4'h0;
		o_cfg_wdata = 32'h0000_0000;
	end

	// one-cycle request; on release address and write data are inverted so stale values never match
	task access(input logic we, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic ack, output logic [31:0] rd);
		@(negedge i_sys_clk);
		o_cfg_req   = 1'b1;
		o_cfg_we    = we;
		o_cfg_addr  = a;
		o_cfg_be    = be;
		o_cfg_wdata = d;
		@(negedge i_sys_clk);
		ack         = i_cfg_ack;
		rd          = i_cfg_rdata;
		o_cfg_req   = 1'b0;
		o_cfg_addr  = ~a;
		o_cfg_wdata = ~d;
	endtask : access
endmodule : pm_host_model

/* testbench.sv */
/*
 * self-checking bench for the power-management block.
 * assumes the host model drives all configuration accesses.
 */
`timescale 1ns/1ps
module testbench;
	import pm_pkg::*;
	logic        clk = 1'b0;
	logic        srst, clk_en, cfg_req, cfg_we, cfg_ack, mem_req, mem_en, mem_ack, irq;
	logic        inta_n, rx_run, in_d3, drv_en, pme_out, pme_oe, ack;
	logic [7:0]  cfg_addr, rx_pin;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, msr_delta, rd;
	int          bad_count = 0;
	int          n_tests = 0;

	always #2.5 clk = ~clk;

	pci_power_mgmt_states pci_power_mgmt_states_i (.i_sys_clk(clk), .i_srst(srst),
		.i_clk_en(clk_en), .i_cfg_req(cfg_req), .i_cfg_we(cfg_we), .i_cfg_addr(cfg_addr),
		.i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata), .o_cfg_ack(cfg_ack),
		.o_cfg_rdata(cfg_rdata), .i_mem_req(mem_req), .i_mem_space_en(mem_en),
		.o_mem_ack(mem_ack), .i_uart_irq(irq), .i_rx_pin(rx_pin), .i_msr_delta(msr_delta),
		.o_inta_n(inta_n), .o_rx_run(rx_run), .o_in_d3hot(in_d3), .o_pci_drv_en(drv_en),
		.o_pme_out(pme_out), .o_pme_oe(pme_oe));
	pm_host_model pm_host_model_i (.i_sys_clk(clk), .i_cfg_ack(cfg_ack),
		.i_cfg_rdata(cfg_rdata), .o_cfg_req(cfg_req), .o_cfg_we(cfg_we),
		.o_cfg_addr(cfg_addr), .o_cfg_be(cfg_be), .o_cfg_wdata(cfg_wdata));

	task end_sim;
		$display("mismatches %0d of %0d checks", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : check

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		pm_host_model_i.access(1'b0, a, 4'h0, 32'h0000_0000, ack, rd);
		check(ack, 1);
		check(rd, exp);
	endtask : rdc

	task wrc(input logic [3:0] be, input logic [31:0] d);
		pm_host_model_i.access(1'b1, CSW_OFS, be, d, ack, rd);
		check(ack, 1);
	endtask : wrc

	// memory claim pulse, sampled one cycle after the request edge
	task mem(input logic exp);
		@(negedge clk);
		mem_req = 1'b1;
		@(negedge clk);
		check(mem_ack, exp);
		mem_req = 1'b0;
	endtask : mem

	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	// main sequence: reset, capability, state changes, wake events, reset again
	initial begin
		srst = 1'b1;
		clk_en = 1'b1;
		mem_req = 1'b0;
		mem_en = 1'b0;
		irq = 1'b1;
		rx_pin = 8'hff;
		msr_delta = 32'h0000_0000;
		tick(8);
		srst = 1'b0;
		rdc(CAP_PTR_OFS, 32'h0000_0040);
		rdc(CAPW_OFS, 32'h400a_0001);
		rdc(CSW_OFS, 32'h0000_0000);
		mem(1'b0);
		mem_en = 1'b1;
		tick(2);
		mem(1'b1);
		check(inta_n, 0);
		pm_host_model_i.access(1'b0, 8'h48, 4'h0, 32'h0000_0000, ack, rd);
		check(ack, 0);
		for (int c = 1; c < 3; c++) begin
			wrc(4'h1, c);
			rdc(CSW_OFS, 32'h0000_0000);
		end
		wrc(4'h1, 32'hffff_ffff);
		check(in_d3, 1);
		rdc(CSW_OFS, 32'h0000_0003);
		mem(1'b0);
		check(inta_n, 1);
		check(rx_run, 1);
		rx_pin[3] = 1'b0;
		tick(4);
		rx_pin[3] = 1'b1;
		tick(3);
		check(pme_oe, 0);
		rdc(CSW_OFS, 32'h0000_8003);
		wrc(4'h2, 32'h0000_0100);
		tick(2);
		check(pme_oe, 1);
		check(pme_out, 0);
		for (int c = 0; c < 8; c++) begin
			wrc(4'h2, 32'h0000_8100);
			tick(2);
			check(pme_oe, 0);
			rdc(CSW_OFS, 32'h0000_0103);
			msr_delta[c * 4 + c % 4] = 1'b1;
			tick(2);
			msr_delta = 32'h0000_0000;
			tick(2);
			rdc(CSW_OFS, 32'h0000_8103);
		end
		wrc(4'h1, 32'h0000_0000);
		check(drv_en, 0);
		check(in_d3, 0);
		pm_host_model_i.access(1'b0, CSW_OFS, 4'h0, 32'h0000_0000, ack, rd);
		check(ack, 0);
		// bounded wait for the drivers to come back
		for (int i = 0; i <= 40; i++) begin
			if (drv_en === 1'b1) begin
				break;
			end
			if (i == 40) begin
				bad_count++;
				end_sim;
			end
			tick(1);
		end
		rdc(CSW_OFS, 32'h0000_8100);
		mem(1'b1);
		// a low clock enable must freeze the block: the write is neither taken nor answered
		clk_en = 1'b0;
		pm_host_model_i.access(1'b1, CSW_OFS, 4'h1, 32'h0000_0003, ack, rd);
		check(ack, 0);
		check(in_d3, 0);
		clk_en = 1'b1;
		tick(1);
		wrc(4'h1, 32'h0000_0003);
		srst = 1'b1;
		tick(2);
		srst = 1'b0;
		check(in_d3, 0);
		check(pme_oe, 0);
		rdc(CSW_OFS, 32'h0000_0000);
		end_sim;
	end
endmodule : testbench
